/* File: design/line_status_map.vh */
`ifndef LINE_STATUS_MAP_VH
`define LINE_STATUS_MAP_VH
// ----------------------------------------
// Register byte addresses
// ----------------------------------------
`define ADDR_DLY_LOW      8'h31
`define ADDR_DLY_HIGH     8'h32
`define ADDR_MS_RX        8'h34
`define ADDR_MS_TX        8'h38
`define ADDR_IF_SEL       8'h40
`define ADDR_CTRL         8'h44
`define ADDR_IRQ_STA      8'h48
`define ADDR_IRQ_MSK      8'h4C
`define ADDR_D_RX_SBIT    8'h50
// ----------------------------------------
// Field positions
// ----------------------------------------
`define MS_RX_RDY_BIT     4
`define MS_UP_S_BIT       6
`define MS_TX_RDY_BIT     7
`define CTRL_UP_BIT       0
`define CTRL_NT_BIT       1
`define IRQ_RX_BIT        0
`define IRQ_TX_BIT        1
`define IRQ_DLY_BIT       2
// ----------------------------------------
// Timing
// ----------------------------------------
`define CLK_HZ            40000000
`define REFRESH_US        250
`define REFRESH_CYCLES    ((`CLK_HZ / 1000000) * `REFRESH_US)
`define MIN_DLY_BITS      2
`define STEPS_PER_BIT     32
`define DLY_W             10
// Shortest legal loop: two bit times of thirty-two steps each.
`define DLY_FLOOR         10'h040
// Last count of the 250 us refresh period at 40 MHz.
`define REFRESH_LAST      14'h270F
`define ZERO8             8'h00
`endif

/* File: design/pin_sync.v */
`timescale 1ns/1ps
module pin_sync (
  // Clock and reset
  input  wire clk_sys_in,
  input  wire arst_n_in,
  // Pin
  input  wire pin_in,
  output reg  level_out,
  output reg  rise_out
);
  reg s1;
  reg s2;
  reg s3;
  always @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      s1        <= 1'b0;
      s2        <= 1'b0;
      s3        <= 1'b0;
      level_out <= 1'b0;
      rise_out  <= 1'b0;
    end else begin
      s1       <= pin_in;
      s2       <= s1;
      s3       <= s2;
      rise_out <= 1'b0;
      // A change counts only once the second and third stages agree.
      if (s2 == s3) begin
        level_out <= s3;
        rise_out  <= s3 & ~level_out;
      end
    end
  end
endmodule

/* File: design/delay_counter.v */
`timescale 1ns/1ps
`include "line_status_map.vh"
module delay_counter (
  // Clock and reset
  input  wire                clk_sys_in,
  input  wire                arst_n_in,
  // Events
  input  wire                start_in,
  input  wire                stop_in,
  input  wire                tick_in,
  // Result
  output reg  [`DLY_W-1:0]   count_out,
  output reg                 done_out
);
  reg running;
  always @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      running   <= 1'b0;
      count_out <= {`DLY_W{1'b0}};
      done_out  <= 1'b0;
    end else begin
      done_out <= 1'b0;
      if (start_in) begin
        running   <= 1'b1;
        count_out <= {`DLY_W{1'b0}};
      end else if (running && stop_in) begin
        running  <= 1'b0;
        done_out <= 1'b1;
      end else if (running && tick_in && count_out != {`DLY_W{1'b1}}) begin
        // Saturate rather than wrap so an overlong loop reads as maximum.
        count_out <= count_out + {{(`DLY_W-1){1'b0}}, 1'b1};
      end
    end
  end
endmodule

/* File: design/line_delay_and_multiframe_status.v */
`timescale 1ns/1ps
`include "line_status_map.vh"
module line_delay_and_multiframe_status (
  // Clock and reset
  input  wire        clk_sys_in,
  input  wire        arst_n_in,
  // APB slave
  input  wire        psel_in,
  input  wire        penable_in,
  input  wire        pwrite_in,
  input  wire [7:0]  paddr_in,
  input  wire [31:0] pwdata_in,
  output reg  [31:0] prdata_out,
  output reg         pready_out,
  output reg         pslverr_out,
  // Line framer pins (from the line logic, asynchronous to this clock)
  input  wire        base_tick_in,
  input  wire        tx_frame_mark_in,
  input  wire        rx_frame_mark_in,
  input  wire        rx_maint_bit_in,
  input  wire        rx_maint_valid_in,
  input  wire        rx_sbit_in,
  input  wire        rx_sbit_valid_in,
  input  wire        tx_slot_free_in,
  // Interface 0 outputs
  output reg  [3:0]  tx_maint_bits_out,
  output reg         s_bit_mirror_out,
  output reg         irq_out
);
  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  // Each pin passes three flops, so every edge is seen three to four cycles late.
  wire tick_rise;
  wire tx_mark_rise;
  wire rx_mark_rise;
  wire maint_rise;
  wire sbit_rise;
  wire slot_rise;
  wire maint_lvl;
  wire sbit_lvl;
  pin_sync u_tick (
    .clk_sys_in (clk_sys_in),
    .arst_n_in  (arst_n_in),
    .pin_in     (base_tick_in),
    .level_out  (),
    .rise_out   (tick_rise)
  );
  pin_sync u_txm (
    .clk_sys_in (clk_sys_in),
    .arst_n_in  (arst_n_in),
    .pin_in     (tx_frame_mark_in),
    .level_out  (),
    .rise_out   (tx_mark_rise)
  );
  pin_sync u_rxm (
    .clk_sys_in (clk_sys_in),
    .arst_n_in  (arst_n_in),
    .pin_in     (rx_frame_mark_in),
    .level_out  (),
    .rise_out   (rx_mark_rise)
  );
  pin_sync u_mv (
    .clk_sys_in (clk_sys_in),
    .arst_n_in  (arst_n_in),
    .pin_in     (rx_maint_valid_in),
    .level_out  (),
    .rise_out   (maint_rise)
  );
  pin_sync u_mb (
    .clk_sys_in (clk_sys_in),
    .arst_n_in  (arst_n_in),
    .pin_in     (rx_maint_bit_in),
    .level_out  (maint_lvl),
    .rise_out   ()
  );
  pin_sync u_sv (
    .clk_sys_in (clk_sys_in),
    .arst_n_in  (arst_n_in),
    .pin_in     (rx_sbit_valid_in),
    .level_out  (),
    .rise_out   (sbit_rise)
  );
  pin_sync u_sb (
    .clk_sys_in (clk_sys_in),
    .arst_n_in  (arst_n_in),
    .pin_in     (rx_sbit_in),
    .level_out  (sbit_lvl),
    .rise_out   ()
  );
  pin_sync u_ts (
    .clk_sys_in (clk_sys_in),
    .arst_n_in  (arst_n_in),
    .pin_in     (tx_slot_free_in),
    .level_out  (),
    .rise_out   (slot_rise)
  );

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  // Only interface 0 is built; with another interface selected its multiframe registers
  // read zero and ignore writes, while the delay and S bit registers still read as for interface 0.
  reg              if_sel;
  reg  [1:0]       ctrl;
  reg  [2:0]       irq_msk;
  reg  [2:0]       irq_sta;
  reg  [3:0]       ms_rx_bits;
  reg  [3:0]       ms_shift;
  reg  [1:0]       ms_cnt;
  reg              rx_rdy;
  reg              tx_rdy;
  reg              up_sbit;
  reg  [`DLY_W-1:0] dly_snap;
  reg  [`DLY_W-1:0] dly_last;
  reg  [13:0]      refresh_cnt;
  reg  [31:0]      next_rdata;
  wire [`DLY_W-1:0] dly_count;
  wire             dly_done;
  wire             up_mode = ctrl[`CTRL_UP_BIT];
  wire             nt_mode = ctrl[`CTRL_NT_BIT];
  wire             sel0    = (if_sel == 1'b0);
  wire             apb_acc = psel_in & penable_in;
  // Side effects of an access land only on its first access edge, the edge that also
  // captures read data; a second edge would clear an event that arrived in between.
  wire             apb_take = apb_acc & ~pready_out;
  wire             apb_wr  = apb_take & pwrite_in;
  wire             apb_rd  = apb_take & ~pwrite_in;
  wire             refresh = (refresh_cnt == `REFRESH_LAST);

  function [`DLY_W-1:0] floor_min;
    input [`DLY_W-1:0] v;
    begin
      // Frame offset or guard time makes anything shorter impossible.
      if (v < `DLY_FLOOR)
        floor_min = `DLY_FLOOR;
      else
        floor_min = v;
    end
  endfunction

  // ----------------------------------------
  // Round trip measurement
  // ----------------------------------------
  // The tick pin carries the 1/32 bit reference of whichever line mode is active,
  // so one counter serves S/T (162.8 ns) and Up (81.4 ns) alike.
  delay_counter u_dly (
    .clk_sys_in (clk_sys_in),
    .arst_n_in  (arst_n_in),
    .start_in   (tx_mark_rise & nt_mode),
    .stop_in    (rx_mark_rise),
    .tick_in    (tick_rise),
    .count_out  (dly_count),
    .done_out   (dly_done)
  );

  always @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in)
      refresh_cnt <= 14'h0000;
    else
      refresh_cnt <= refresh ? 14'h0000 : refresh_cnt + 14'h0001;
  end

  // Both halves are served from one snapshot taken at each refresh in NT mode, so reading high then low mixes two
  // measurements only when a refresh falls between the two reads.
  always @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      dly_last    <= {`DLY_W{1'b0}};
      dly_snap    <= {`DLY_W{1'b0}};
    end else begin
      if (dly_done)
        dly_last <= floor_min(dly_count);
      if (refresh && nt_mode)
        dly_snap <= dly_last;
    end
  end

  // ----------------------------------------
  // Multiframe receive and transmit flags
  // ----------------------------------------
  wire rd_ms_rx = apb_rd && paddr_in == `ADDR_MS_RX && sel0;
  wire wr_ms_tx = apb_wr && paddr_in == `ADDR_MS_TX && sel0;
  wire rx_set   = maint_rise && ms_cnt == 2'h3;

  always @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      ms_shift          <= 4'h0;
      ms_cnt            <= 2'h0;
      ms_rx_bits        <= 4'h0;
      rx_rdy            <= 1'b0;
      tx_rdy            <= 1'b0;
      up_sbit           <= 1'b0;
      tx_maint_bits_out <= 4'h0;
      s_bit_mirror_out  <= 1'b0;
    end else begin
      if (maint_rise) begin
        ms_shift <= {ms_shift[2:0], maint_lvl};
        ms_cnt   <= ms_cnt + 2'h1;
      end
      // First received bit lands in bit 3: S1/Q1 or T1a.
      if (rx_set)
        ms_rx_bits <= {ms_shift[2:0], maint_lvl};
      // A multiframe that completes in the cycle of a read wins, so it is never lost.
      if (rx_set)
        rx_rdy <= 1'b1;
      else if (rd_ms_rx)
        rx_rdy <= 1'b0;
      if (slot_rise)
        tx_rdy <= 1'b1;
      else if (wr_ms_tx)
        tx_rdy <= 1'b0;
      if (wr_ms_tx)
        tx_maint_bits_out <= pwdata_in[3:0];
      if (sbit_rise && up_mode) begin
        up_sbit          <= sbit_lvl;
        s_bit_mirror_out <= sbit_lvl;
      end
    end
  end

  // ----------------------------------------
  // Interrupts
  // ----------------------------------------
  reg  [2:0] irq_evt;

  always @* begin
    irq_evt               = 3'h0;
    irq_evt[`IRQ_RX_BIT]  = rx_set;
    irq_evt[`IRQ_TX_BIT]  = slot_rise;
    irq_evt[`IRQ_DLY_BIT] = refresh & nt_mode;
  end

  always @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      irq_sta <= 3'h0;
      irq_out <= 1'b0;
    end else begin
      if (apb_wr && paddr_in == `ADDR_IRQ_STA)
        irq_sta <= (irq_sta & ~pwdata_in[2:0]) | irq_evt;
      else
        irq_sta <= irq_sta | irq_evt;
      irq_out <= |(irq_sta & irq_msk);
    end
  end

  // ----------------------------------------
  // APB slave
  // ----------------------------------------
  always @* begin
    next_rdata = 32'h0000_0000;
    if (paddr_in == `ADDR_DLY_LOW)
      next_rdata = {27'h0000000, dly_snap[4:0]};
    else if (paddr_in == `ADDR_DLY_HIGH)
      next_rdata = {27'h0000000, dly_snap[9:5]};
    else if (paddr_in == `ADDR_MS_RX && sel0) begin
      next_rdata[3:0]            = ms_rx_bits;
      next_rdata[`MS_RX_RDY_BIT] = rx_rdy;
      next_rdata[`MS_UP_S_BIT]   = up_sbit & up_mode;
      next_rdata[`MS_TX_RDY_BIT] = tx_rdy;
    end else if (paddr_in == `ADDR_IF_SEL)
      next_rdata = {31'h00000000, if_sel};
    else if (paddr_in == `ADDR_CTRL)
      next_rdata = {30'h00000000, ctrl};
    else if (paddr_in == `ADDR_IRQ_STA)
      next_rdata = {29'h00000000, irq_sta};
    else if (paddr_in == `ADDR_IRQ_MSK)
      next_rdata = {29'h00000000, irq_msk};
    else if (paddr_in == `ADDR_D_RX_SBIT)
      next_rdata = {31'h00000000, up_sbit};
  end

  // Anything not listed here answers with an error and reads zero.
  function addr_mapped;
    input [7:0] a;
    begin
      if (a == `ADDR_DLY_LOW)
        addr_mapped = 1'b1;
      else if (a == `ADDR_DLY_HIGH)
        addr_mapped = 1'b1;
      else if (a == `ADDR_MS_RX)
        addr_mapped = 1'b1;
      else if (a == `ADDR_MS_TX)
        addr_mapped = 1'b1;
      else if (a == `ADDR_IF_SEL)
        addr_mapped = 1'b1;
      else if (a == `ADDR_CTRL)
        addr_mapped = 1'b1;
      else if (a == `ADDR_IRQ_STA)
        addr_mapped = 1'b1;
      else if (a == `ADDR_IRQ_MSK)
        addr_mapped = 1'b1;
      else if (a == `ADDR_D_RX_SBIT)
        addr_mapped = 1'b1;
      else
        addr_mapped = 1'b0;
    end
  endfunction

  wire mapped = addr_mapped(paddr_in);

  // ----------------------------------------
  // Handshake and register writes
  // ----------------------------------------
  // One wait state: pready rises in the second access cycle so outputs stay registered.
  always @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      if_sel      <= 1'b0;
      ctrl        <= 2'h0;
      irq_msk     <= 3'h0;
      prdata_out  <= 32'h0000_0000;
      pready_out  <= 1'b0;
      pslverr_out <= 1'b0;
    end else begin
      pready_out  <= apb_acc & ~pready_out;
      pslverr_out <= apb_acc & ~pready_out & ~mapped;
      prdata_out  <= (apb_rd & ~pready_out) ? next_rdata : 32'h0000_0000;
      if (apb_wr && !pready_out) begin
        if (paddr_in == `ADDR_IF_SEL)
          if_sel <= pwdata_in[0];
        else if (paddr_in == `ADDR_CTRL)
          ctrl <= pwdata_in[1:0];
        else if (paddr_in == `ADDR_IRQ_MSK)
          irq_msk <= pwdata_in[2:0];
      end
    end
  end
endmodule

/* File: sim/line_status_chk.sv */
`timescale 1ns/1ps
`include "line_status_map.vh"
module line_status_chk (
  // Clock and reset
  input wire        clk_sys_in,
  input wire        arst_n_in,
  // Register bus
  input wire        psel_in,
  input wire        penable_in,
  input wire        pwrite_in,
  input wire [7:0]  paddr_in,
  input wire [31:0] prdata_out,
  input wire        pready_out,
  input wire        pslverr_out,
  // Line side
  input wire [3:0]  tx_maint_bits_out
);
  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (!arst_n_in);
  // -----------------
  // Helper logic
  // -----------------
  // An access phase that is still waiting for its answer.
  wire acc = psel_in && penable_in && !pready_out;
  wire rd  = acc && !pwrite_in;
  reg  tx_wr;
  always @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      tx_wr <= 1'h0;
    end else begin
      tx_wr <= psel_in && penable_in && pwrite_in && paddr_in == `ADDR_MS_TX;
    end
  end
  // -----------------
  // Properties
  // -----------------
  a_ready_one_wait: assert property (acc |=> pready_out)
    else $error("answer missing one cycle after the access edge");
  a_ready_pulse: assert property (pready_out |=> !pready_out)
    else $error("answer held longer than one cycle");
  a_idle_quiet: assert property (!pready_out |-> prdata_out == 32'h0 && !pslverr_out)
    else $error("read data or error outside the answer cycle");
  a_dlyh_reserved: assert property (rd && paddr_in == `ADDR_DLY_HIGH |=>
    prdata_out[31:5] == 27'h0)
    else $error("reserved delay bits not zero");
  a_rx_reserved: assert property (rd && paddr_in == `ADDR_MS_RX |=>
    !prdata_out[5] && prdata_out[31:8] == 24'h0)
    else $error("reserved receive status bits not zero");
  a_unmapped_err: assert property (acc && paddr_in == 8'h3C |=> pslverr_out && prdata_out == 32'h0)
    else $error("unmapped access not refused");
  a_mapped_ok: assert property (acc && paddr_in == `ADDR_MS_RX |=>
    pready_out && !pslverr_out)
    else $error("mapped access refused");
  a_tx_bits_cause: assert property (!$stable(tx_maint_bits_out) |-> tx_wr)
    else $error("transmit bits changed without a write");
endmodule
bind line_delay_and_multiframe_status line_status_chk line_status_chk_inst (
  .clk_sys_in        (clk_sys_in),
  .arst_n_in         (arst_n_in),
  .psel_in           (psel_in),
  .penable_in        (penable_in),
  .pwrite_in         (pwrite_in),
  .paddr_in          (paddr_in),
  .prdata_out        (prdata_out),
  .pready_out        (pready_out),
  .pslverr_out       (pslverr_out),
  .tx_maint_bits_out (tx_maint_bits_out)
);

/* File: sim/line_model.sv */
`timescale 1ns/1ps
module line_model (
  // Clock
  input  wire logic clk_sys_in,
  // Line pins toward the device
  output logic      base_tick_out,
  output logic      tx_mark_out,
  output logic      rx_mark_out,
  output logic      maint_bit_out,
  output logic      maint_valid_out,
  output logic      sbit_out,
  output logic      sbit_valid_out,
  output logic      slot_free_out
);
  logic [2:0] div = 3'h0;
  initial {tx_mark_out, rx_mark_out, maint_bit_out, maint_valid_out} = 4'h0;
  initial {sbit_out, sbit_valid_out, slot_free_out} = 3'h0;
  // The reference tick runs free, one rising edge every eight cycles.
  always @(posedge clk_sys_in) div <= div + 3'h1;
  assign base_tick_out = div[2];
  task automatic hold(input int n);
    repeat (n) @(posedge clk_sys_in);
  endtask
  // Levels stand four cycles so the three-flop synchroniser cannot miss them.
  // Data lines flip after the strobe, so nothing stale looks valid.
  task automatic strobe(input logic s, input logic b);
    hold(1);
    {sbit_out, maint_bit_out} <= {b, b};
    hold(4);
    {sbit_valid_out, maint_valid_out} <= {s, !s};
    hold(4);
    {sbit_valid_out, maint_valid_out} <= 2'h0;
    {sbit_out, maint_bit_out} <= {~b, ~b};
  endtask
  task automatic send_maint(input logic [3:0] b);
    for (int i = 3; i >= 0; i--) strobe(1'h0, b[i]);
  endtask
  task automatic measure(input int n);
    hold(1);
    tx_mark_out <= 1'h1;
    repeat (n) @(posedge base_tick_out);
    hold(1);
    rx_mark_out <= 1'h1;
    hold(4);
    tx_mark_out <= 1'h0;
    rx_mark_out <= 1'h0;
  endtask
  task automatic slot_free;
    hold(1);
    slot_free_out <= 1'h1;
    hold(4);
    slot_free_out <= 1'h0;
  endtask
endmodule

/* File: sim/tb.sv */
`timescale 1ns/1ps
`include "line_status_map.vh"
module tb;
  logic        clk_sys_in = 1'h0;
  logic        arst_n_in = 1'h0;
  logic        psel_in = 1'h0;
  logic        penable_in = 1'h0;
  logic        pwrite_in = 1'h0;
  logic [7:0]  paddr_in = 8'h00;
  logic [31:0] pwdata_in = 32'h0;
  wire  [31:0] prdata_out;
  wire         pready_out, pslverr_out, s_bit_mirror_out, irq_out;
  wire  [3:0]  tx_maint_bits_out;
  wire         base_tick_in, tx_frame_mark_in, rx_frame_mark_in, rx_maint_bit_in;
  wire         rx_maint_valid_in, rx_sbit_in, rx_sbit_valid_in, tx_slot_free_in;
  int          fail_count = 0;
  int          tests_run = 0;
  int          cycles = 0;
  logic [31:0] rdata;
  logic        rerr;
  always #12.5 clk_sys_in = ~clk_sys_in;
  line_delay_and_multiframe_status line_delay_and_multiframe_status_inst (
    .clk_sys_in        (clk_sys_in),
    .arst_n_in         (arst_n_in),
    .psel_in           (psel_in),
    .penable_in        (penable_in),
    .pwrite_in         (pwrite_in),
    .paddr_in          (paddr_in),
    .pwdata_in         (pwdata_in),
    .prdata_out        (prdata_out),
    .pready_out        (pready_out),
    .pslverr_out       (pslverr_out),
    .base_tick_in      (base_tick_in),
    .tx_frame_mark_in  (tx_frame_mark_in),
    .rx_frame_mark_in  (rx_frame_mark_in),
    .rx_maint_bit_in   (rx_maint_bit_in),
    .rx_maint_valid_in (rx_maint_valid_in),
    .rx_sbit_in        (rx_sbit_in),
    .rx_sbit_valid_in  (rx_sbit_valid_in),
    .tx_slot_free_in   (tx_slot_free_in),
    .tx_maint_bits_out (tx_maint_bits_out),
    .s_bit_mirror_out  (s_bit_mirror_out),
    .irq_out           (irq_out)
  );
  line_model line_model_inst (.clk_sys_in(clk_sys_in), .base_tick_out(base_tick_in),
    .tx_mark_out(tx_frame_mark_in), .rx_mark_out(rx_frame_mark_in),
    .maint_bit_out(rx_maint_bit_in), .maint_valid_out(rx_maint_valid_in),
    .sbit_out(rx_sbit_in), .sbit_valid_out(rx_sbit_valid_in), .slot_free_out(tx_slot_free_in));
  // -----------------
  // Tasks
  // -----------------
  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys_in);
    psel_in <= 1'h1;
    pwrite_in <= w;
    paddr_in <= a;
    pwdata_in <= d;
    @(posedge clk_sys_in);
    penable_in <= 1'h1;
    do @(posedge clk_sys_in); while (pready_out !== 1'h1);
    rdata = prdata_out;
    rerr = pslverr_out;
    psel_in <= 1'h0;
    penable_in <= 1'h0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'h1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic ee = 1'h0);
    apb(1'h0, a, 32'h0);
    chk(rdata, e);
    chk({31'h0, rerr}, {31'h0, ee});
  endtask
  task automatic settle;
    repeat (6) @(posedge clk_sys_in);
  endtask
  // -----------------
  // Sequence
  // -----------------
  always @(posedge clk_sys_in) begin
    cycles++;
    if (cycles == 60000) begin
      fail_count++;
      finish_test();
    end
  end
  initial begin
    repeat (16) @(posedge clk_sys_in);
    arst_n_in <= 1'h1;
    rd(`ADDR_MS_RX, 32'h0);
    rd(8'h3C, 32'h0, 1'h1);
    wr(`ADDR_IF_SEL, 32'h0);
    wr(`ADDR_CTRL, 32'h2);
    wr(`ADDR_IRQ_MSK, 32'h0);
    line_model_inst.send_maint(4'hA);
    settle();
    rd(`ADDR_IRQ_STA, 32'h1);
    chk({31'h0, irq_out}, 32'h0);
    wr(`ADDR_IRQ_MSK, 32'h1);
    settle();
    chk({31'h0, irq_out}, 32'h1);
    wr(`ADDR_IRQ_STA, 32'h1);
    settle();
    chk({31'h0, irq_out}, 32'h0);
    rd(`ADDR_MS_RX, 32'h1A);
    rd(`ADDR_MS_RX, 32'h0A);
    line_model_inst.slot_free();
    settle();
    rd(`ADDR_IRQ_STA, 32'h2);
    rd(`ADDR_MS_RX, 32'h8A);
    wr(`ADDR_MS_TX, 32'h5);
    chk({28'h0, tx_maint_bits_out}, 32'h5);
    rd(`ADDR_MS_RX, 32'h0A);
    wr(`ADDR_IF_SEL, 32'h1);
    rd(`ADDR_MS_RX, 32'h0);
    wr(`ADDR_IF_SEL, 32'h0);
    // A short loop is raised to the two-bit floor, so both halves are exact.
    line_model_inst.measure(10);
    repeat (10100) @(posedge clk_sys_in);
    rd(`ADDR_DLY_HIGH, 32'h2);
    rd(`ADDR_DLY_LOW, 32'h0);
    rd(`ADDR_IRQ_STA, 32'h6);
    line_model_inst.measure(112);
    repeat (10100) @(posedge clk_sys_in);
    rd(`ADDR_DLY_HIGH, 32'h3);
    wr(`ADDR_CTRL, 32'h3);
    line_model_inst.send_maint(4'h6);
    line_model_inst.strobe(1'h1, 1'h1);
    settle();
    rd(`ADDR_MS_RX, 32'h56);
    chk({31'h0, s_bit_mirror_out}, 32'h1);
    rd(`ADDR_D_RX_SBIT, 32'h1);
    // Outside NT/LT mode a new loop must not reach the readout.
    wr(`ADDR_CTRL, 32'h1);
    line_model_inst.measure(10);
    repeat (10100) @(posedge clk_sys_in);
    rd(`ADDR_DLY_HIGH, 32'h3);
    finish_test();
  end
endmodule
